// ===== inc/clock_control_defs.vh
`ifndef CLOCK_CONTROL_DEFS_VH
`define CLOCK_CONTROL_DEFS_VH

// Clock source codes (decoded from the 4-bit select)
`define SRC_EXTERNAL       3'h0
`define SRC_RC_4MHZ        3'h1
`define SRC_RC_8MHZ        3'h2
`define SRC_WATCHDOG       3'h3
`define SRC_CRYSTAL        3'h4

// Factory defaults
`define DEFAULT_CLOCK_SOURCE_SELECT 4'h2
`define DEFAULT_STARTUP_TIME_SELECT 2'h2
`define DEFAULT_DIVIDE_BY_EIGHT     1'h0

// Fuse polarity
`define FUSE_PROGRAMMED    1'h0

// Start-up select codes
`define SUT_14CK           2'h0
`define SUT_14CK_4MS       2'h1
`define SUT_14CK_65MS      2'h2

// Start-up counts in selected-source clocks
`define WAKE_RC_CLOCKS      16'h0006
`define WAKE_CRYSTAL_SHORT  16'h0102
`define WAKE_CRYSTAL_MID    16'h0400
`define WAKE_CRYSTAL_LONG   16'h4000
`define RESET_SOURCE_CLOCKS 16'h000E

// Reset time-outs in watchdog-oscillator cycles
`define WDOG_SHORT_CYCLES  17'h01000
`define WDOG_LONG_CYCLES   17'h10000

// Divide-by-eight prescaler terminal count
`define PRESCALE_LAST      3'h7

// Register map (word-aligned byte addresses)
`define REG_CONTROL        4'h0
`define REG_STATUS         4'h4
`define REG_FUSES          4'h8

// Control register fields
`define CTRL_CORE_STOP     0
`define CTRL_PERIPH_STOP   1
`define CTRL_PMEM_STOP     2
`define CTRL_POWER_DOWN    3
`define CTRL_PRESCALE_OFF  4

// Status register fields
`define STAT_CORE_RUN      0
`define STAT_PERIPH_RUN    1
`define STAT_PMEM_RUN      2
`define STAT_IN_RESET      3
`define STAT_STARTING      4
`define STAT_ASYNC_IRQ     5
`define STAT_USI_START     6

`endif

// ===== src/clock_control.v
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`include "clock_control_defs.vh"

module clock_control (
   // Clock and reset
   input  wire        clock,
   input  wire        rst,
   // Clock source ticks (levels from oscillator dividers, edge-detected here)
   input  wire        source_tick,
   input  wire        watchdog_tick,
   // Nonvolatile configuration fields
   input  wire [3:0]  clock_source_select,
   input  wire [1:0]  startup_time_select,
   input  wire        divide_by_eight_fuse,
   // Asynchronous wake inputs
   input  wire        ext_interrupt_pin,
   input  wire        usi_start_pin,
   // Avalon-MM slave
   input  wire [3:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output wire        waitrequest,
   // Clock enables, core reset, source code and wake flag toward the domains
   output reg         core_clock,
   output reg         peripheral_clock,
   output reg         program_memory_clock,
   output reg         core_reset,
   output reg  [2:0]  selected_source,
   output reg         async_wake
);

   // Overview of the start-up flow
   // After reset the sequencer first counts watchdog cycles
   // The count chosen by the start-up select is 0, 4096 or 65536
   // Reserved start-up code is treated like the no-delay code for the reset time-out
   // Then fourteen edges of the selected source are counted
   // Only then the core leaves reset and enables begin to pulse
   // Enables pulse once per source edge, or once per eight
   // The divide fuse reads zero when programmed
   // Software can bypass the divider through the control register
   // Power-down parks the sequencer until a wake source shows
   // Wake sources are the interrupt pin and the serial start pin
   // Both pins pass two flip-flops before anything reads them
   // On wake the power-down bit clears itself
   // The wake length is counted in source edges again
   // Internal RC wakes after six edges
   // Crystal wake length depends on select bit zero and start-up code
   // The three clock outputs toward the domains are one-cycle enables; core reset is a level
   // No derived clock is generated, so no clock crossing exists
   // Oscillator ticks arrive as levels and are edge-detected here
   // A tick shorter than two system clocks may be lost
   // The register bus always answers after one wait state

   // Start-up sequencer states
   localparam ST_RESET_WAIT = 2'h0;
   localparam ST_RESET_CK   = 2'h1;
   localparam ST_RUN        = 2'h2;
   localparam ST_WAKE       = 2'h3;

   reg  [1:0]  state;            // Sequencer state
   reg  [16:0] wdog_count;       // Watchdog-cycle counter
   reg  [15:0] src_count;        // Source-clock counter
   reg  [2:0]  prescale;         // Divide-by-eight counter
   reg  [4:0]  control;          // Software control bits
   reg         answered;         // Bus answer already given
   reg  [1:0]  irq_sync;         // Interrupt pin synchroniser
   reg  [1:0]  usi_sync;         // Serial start synchroniser
   reg  [1:0]  src_sync;         // Source tick synchroniser
   reg  [1:0]  wdg_sync;         // Watchdog tick synchroniser
   reg         src_prev;         // Source tick edge history
   reg         wdg_prev;         // Watchdog tick edge history
   reg  [16:0] wdog_target;      // Reset time-out length
   reg  [15:0] wake_target;      // Wake-up length
   reg  [2:0]  next_source;      // Decoded source
   reg         factory_default;  // Fuse fields hold shipped values
   wire        src_edge;         // Selected source rose
   wire        wdg_edge;         // Watchdog oscillator rose
   wire        divide_on;        // Prescaler active
   wire        sys_tick;         // System clock enable after prescale
   wire        sleeping;         // Power-down requested

   assign src_edge  = src_sync[1] & ~src_prev;
   assign wdg_edge  = wdg_sync[1] & ~wdg_prev;
   // Programmed fuse reads as zero
   assign divide_on = (divide_by_eight_fuse == `FUSE_PROGRAMMED) & ~control[`CTRL_PRESCALE_OFF];
   assign sys_tick  = src_edge & (~divide_on | (prescale == `PRESCALE_LAST));
   assign sleeping  = control[`CTRL_POWER_DOWN];
   // One wait state on every access
   assign waitrequest = (read | write) & ~answered;

   // Source decode from select field
   always @* begin
      case (clock_source_select[3:1])
         3'h0:    next_source = `SRC_EXTERNAL;
         3'h1:    next_source = `SRC_RC_4MHZ;
         3'h2:    next_source = `SRC_RC_8MHZ;
         3'h3:    next_source = `SRC_WATCHDOG;
         default: next_source = `SRC_CRYSTAL;
      endcase
   end

   // Reset time-out from start-up select
   always @* begin
      case (startup_time_select)
         `SUT_14CK_4MS:  wdog_target = `WDOG_SHORT_CYCLES;
         `SUT_14CK_65MS: wdog_target = `WDOG_LONG_CYCLES;
         default:        wdog_target = 17'h00000;
      endcase
   end

   // Wake-up length depends on source
   always @* begin
      if (next_source == `SRC_CRYSTAL) begin
         if (clock_source_select[0] == 1'b0 && startup_time_select[1] == 1'b0)
            wake_target = `WAKE_CRYSTAL_SHORT;
         else if (clock_source_select[0] == 1'b0 || startup_time_select == 2'h0)
            wake_target = `WAKE_CRYSTAL_MID;
         else
            wake_target = `WAKE_CRYSTAL_LONG;
      end else begin
         wake_target = `WAKE_RC_CLOCKS;
      end
   end

   // Synchroniser notes
   // Pins and oscillator ticks come from outside the clock domain
   // The first stage may go metastable and is never read by logic
   // Only the second stage feeds edge detectors and wake logic
   // Edge history registers reset low, matching idle tick level
   // So no false edge follows the release of reset
   // Two-stage synchronisers for pins and oscillator ticks
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_sync <= 2'h0;
         usi_sync <= 2'h0;
         src_sync <= 2'h0;
         wdg_sync <= 2'h0;
         src_prev <= 1'b0;
         wdg_prev <= 1'b0;
      end else begin
         irq_sync <= {irq_sync[0], ext_interrupt_pin};
         usi_sync <= {usi_sync[0], usi_start_pin};
         src_sync <= {src_sync[0], source_tick};
         wdg_sync <= {wdg_sync[0], watchdog_tick};
         src_prev <= src_sync[1];
         wdg_prev <= wdg_sync[1];
      end
   end

   // Wake sources seen without any domain clock running
   always @(posedge clock or posedge rst) begin
      if (rst)
         async_wake <= 1'b0;
      else
         async_wake <= irq_sync[1] | usi_sync[1];
   end

   // Prescaler counting source edges
   always @(posedge clock or posedge rst) begin
      if (rst)
         prescale <= 3'h0;
      else if (src_edge)
         prescale <= prescale + 3'h1;
   end

   // Sequencer notes
   // Reset wait counts watchdog edges up to the chosen time-out
   // A zero time-out leaves this state at the first clock, before any watchdog edge
   // Reset count state adds fourteen source edges
   // Run state waits for a power-down request
   // Wake state holds its counter at zero while still asleep
   // Once a wake source shows, source edges are counted
   // The counter compares against the decoded wake length
   // Counters only move on detected edges, never every clock
   // Fuse fields are assumed static while the sequencer runs
   // Start-up sequencer
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state      <= ST_RESET_WAIT;
         wdog_count <= 17'h00000;
         src_count  <= 16'h0000;
      end else begin
         case (state)
            ST_RESET_WAIT: begin
               // Supply settle counted in watchdog cycles
               if (wdog_count >= wdog_target) begin
                  state     <= ST_RESET_CK;
                  src_count <= 16'h0000;
               end else if (wdg_edge) begin
                  wdog_count <= wdog_count + 17'h00001;
               end
            end
            ST_RESET_CK: begin
               // Fixed source clocks after the time-out
               if (src_count >= `RESET_SOURCE_CLOCKS)
                  state <= ST_RUN;
               else if (src_edge)
                  src_count <= src_count + 16'h0001;
            end
            ST_RUN: begin
               if (sleeping) begin
                  state     <= ST_WAKE;
                  src_count <= 16'h0000;
               end
            end
            ST_WAKE: begin
               // Stay down until woken, then count source clocks
               if (sleeping && !async_wake)
                  src_count <= 16'h0000;
               else if (src_count >= wake_target)
                  state <= ST_RUN;
               else if (src_edge)
                  src_count <= src_count + 16'h0001;
            end
            default: state <= ST_RESET_WAIT;
         endcase
      end
   end

   // Enable notes
   // Every enable is a registered copy of the system tick
   // Core and program memory stop together with the core stop bit
   // Program memory can also be stopped on its own
   // Peripherals may keep running while the core is stopped
   // Nothing pulses while in reset, starting or asleep
   // Core reset stays high through both reset counting states
   // Domain clock enables
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         core_clock           <= 1'b0;
         peripheral_clock     <= 1'b0;
         program_memory_clock <= 1'b0;
         core_reset           <= 1'b1;
         selected_source      <= `SRC_EXTERNAL;
      end else begin
         selected_source <= next_source;
         core_reset      <= (state == ST_RESET_WAIT) || (state == ST_RESET_CK);
         // Core gated off while starting or stopped
         core_clock <= sys_tick & (state == ST_RUN) & ~control[`CTRL_CORE_STOP];
         // Flash interface follows the core
         program_memory_clock <= sys_tick & (state == ST_RUN) & ~control[`CTRL_CORE_STOP]
                                 & ~control[`CTRL_PMEM_STOP];
         // Peripherals keep running while core idles
         peripheral_clock <= sys_tick & (state == ST_RUN) & ~control[`CTRL_PERIPH_STOP];
      end
   end

   // Bus notes
   // A request raises waitrequest at once
   // The answered flag rises at the first edge of the request
   // Waitrequest then drops and the second edge takes the access
   // The flag clears again so a back-to-back request waits too
   // Unmapped addresses read zero and ignore writes
   // Bus answer after one wait cycle
   always @(posedge clock or posedge rst) begin
      if (rst)
         answered <= 1'b0;
      else
         answered <= (read | write) & ~answered;
   end

   // Control register writes; power-down self-clears on wake
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         control <= 5'h00;
      end else if (write && answered && address == `REG_CONTROL) begin
         control <= writedata[4:0];
      end else if (state == ST_WAKE && async_wake) begin
         control[`CTRL_POWER_DOWN] <= 1'b0;
      end
   end

   // Read notes
   // Read data loads at the first edge of a read
   // It then stands unchanged while the master takes it
   // Status shows live run and wake states
   // Fuse read-back shows the raw fields and the decoded source
   // Read data mux
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         readdata <= 32'h00000000;
      end else if (read && !answered) begin
         case (address)
            `REG_CONTROL: readdata <= {27'h0000000, control};
            `REG_STATUS:  readdata <= {24'h000000, factory_default, usi_sync[1], irq_sync[1],
                                       state == ST_WAKE, core_reset,
                                       ~control[`CTRL_CORE_STOP] & (state == ST_RUN),
                                       ~control[`CTRL_PERIPH_STOP] & (state == ST_RUN),
                                       ~control[`CTRL_PMEM_STOP] & (state == ST_RUN)};
            `REG_FUSES:   readdata <= {22'h000000, next_source, divide_by_eight_fuse,
                                       startup_time_select, clock_source_select};
            default:      readdata <= 32'h00000000;
         endcase
      end
   end

   // Factory notes
   // Shipped fields select the 4 MHz RC with longest start-up
   // The divide fuse is programmed, so start runs at one eighth
   // Software can see in status whether that setting is in place
   // Factory configuration recognised from the fuse fields
   always @(posedge clock or posedge rst) begin
      if (rst)
         factory_default <= 1'b0;
      else
         factory_default <= (clock_source_select == `DEFAULT_CLOCK_SOURCE_SELECT)
                            & (startup_time_select == `DEFAULT_STARTUP_TIME_SELECT)
                            & (divide_by_eight_fuse == `DEFAULT_DIVIDE_BY_EIGHT);
   end
endmodule

// ===== dv/clock_control_sva.sv
`timescale 1ns/100ps
// Port-level checks of the clock controller
module clock_control_sva (
   // Clock and reset
   input wire       clock,
   input wire       rst,
   // Configuration and wake pins
   input wire [3:0] clock_source_select,
   input wire       ext_interrupt_pin,
   input wire       usi_start_pin,
   // Bus handshake
   input wire       read,
   input wire       write,
   input wire       waitrequest,
   // Domain enables and status
   input wire       core_clock,
   input wire       peripheral_clock,
   input wire       program_memory_clock,
   input wire       core_reset,
   input wire [2:0] selected_source,
   input wire       async_wake
);
   // All checks share the system clock and its reset
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   held_core_a: assert property (core_reset |-> !core_clock)
      else $error("core enable while held");
   source_decode_a: assert property (!$past(rst) && $stable(clock_source_select) |->
      selected_source == (clock_source_select[3] ? 3'h4 : {1'h0, clock_source_select[2:1]}))
      else $error("wrong source decode");
   irq_wake_a: assert property (ext_interrupt_pin [*4] |-> async_wake)
      else $error("interrupt pin not seen");
   start_wake_a: assert property (usi_start_pin [*4] |-> async_wake)
      else $error("start pin not seen");
   wake_quiet_a: assert property ((!ext_interrupt_pin && !usi_start_pin) [*4] |-> !async_wake)
      else $error("wake without cause");
   pmem_with_core_a: assert property (core_clock |-> program_memory_clock)
      else $error("core enable without pmem enable");
   periph_pulse_a: assert property (peripheral_clock |=> !peripheral_clock)
      else $error("peripheral enable too long");
   bus_wait_a: assert property ((read || write) && !$past(read || write) |-> waitrequest ##1 !waitrequest)
      else $error("wrong wait state count");
endmodule

bind clock_control clock_control_sva chk (.clock, .rst, .clock_source_select, .ext_interrupt_pin,
   .usi_start_pin, .read, .write, .waitrequest, .core_clock, .peripheral_clock, .program_memory_clock,
   .core_reset, .selected_source, .async_wake);

// ===== dv/osc_model.sv
`timescale 1ns/100ps
// Oscillator stand-in; ticks rest low between bursts
module osc_model (
   // System clock for pacing
   input wire  clock,
   // Tick levels
   output logic source_tick,
   output logic watchdog_tick
);
   initial source_tick = 1'h0;
   initial watchdog_tick = 1'h0;
   // Selected source clocks, four cycles high and four low
   task automatic src(input int n);
      repeat (n) begin
         source_tick <= 1'h1;
         repeat (4) @(posedge clock);
         source_tick <= 1'h0;
         repeat (4) @(posedge clock);
      end
   endtask
   // Watchdog cycles, two high and two low
   task automatic wdog(input int n);
      repeat (n) begin
         watchdog_tick <= 1'h1;
         repeat (2) @(posedge clock);
         watchdog_tick <= 1'h0;
         repeat (2) @(posedge clock);
      end
   endtask
endmodule

// ===== dv/tb_clock_control.sv
`timescale 1ns/100ps
`include "clock_control_defs.vh"
// Self-checking bench for the clock controller
module tb_clock_control;
   // Design inputs
   logic        clock = 1'h0;
   logic        rst = 1'h1;
   logic [3:0]  clock_source_select = 4'h2;
   logic [1:0]  startup_time_select = 2'h0;
   logic        divide_by_eight_fuse = 1'h1;
   logic        ext_interrupt_pin = 1'h0;
   logic        usi_start_pin = 1'h0;
   logic [3:0]  address = 4'h0;
   logic        read = 1'h0;
   logic        write = 1'h0;
   logic [31:0] writedata = 32'h0;
   // Design outputs and ticks
   wire [31:0]  readdata;
   wire [2:0]   selected_source;
   wire         waitrequest, core_clock, peripheral_clock, program_memory_clock;
   wire         core_reset, async_wake, source_tick, watchdog_tick;
   // Bookkeeping
   int          mismatches = 0, n_checks = 0, ncore = 0, nper = 0, npm = 0;
   logic [31:0] q;

   always #2 clock = ~clock;
   osc_model osc (.clock, .source_tick, .watchdog_tick);
   clock_control dut (.clock, .rst, .source_tick, .watchdog_tick, .clock_source_select, .startup_time_select,
      .divide_by_eight_fuse, .ext_interrupt_pin, .usi_start_pin, .address, .read, .write, .writedata,
      .readdata, .waitrequest, .core_clock, .peripheral_clock, .program_memory_clock, .core_reset,
      .selected_source, .async_wake);

   // Count enable pulses per domain
   always @(posedge clock) begin
      ncore <= ncore + (core_clock === 1'h1);
      nper <= nper + (peripheral_clock === 1'h1);
      npm <= npm + (program_memory_clock === 1'h1);
   end

   // Compare and report
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Verdict and end of run
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // One bus transfer, held until waitrequest is sampled low
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      @(negedge clock);
      while (waitrequest !== 1'h0 && n < 20) begin
         @(negedge clock);
         n++;
      end
      @(posedge clock);
      chk("bus answer", n < 20, 1);
      q = readdata;
      read <= 1'h0;
      write <= 1'h0;
      @(posedge clock);
   endtask
   // Reset with given start-up select and divide fuse
   task restart(input logic [1:0] sut, input logic div);
      rst <= 1'h1;
      startup_time_select <= sut;
      divide_by_eight_fuse <= div;
      repeat (5) @(posedge clock);
      rst <= 1'h0;
      @(posedge clock);
   endtask
   // Run source clocks and compare pulse counts per domain
   task pulses(input int n, input int c, input int p, input int m);
      int c0, p0, m0;
      c0 = ncore;
      p0 = nper;
      m0 = npm;
      osc.src(n);
      chk("core pulses", ncore - c0, c);
      chk("periph pulses", nper - p0, p);
      chk("pmem pulses", npm - m0, m);
   endtask
   // No-delay start-up select: fourteen source clocks, then undivided
   task t_boot;
      restart(2'h0, 1'h1);
      osc.src(13);
      chk("held at 13", core_reset, 1);
      osc.src(1);
      chk("released", core_reset, 0);
      pulses(16, 16, 16, 16);
   endtask
   // Domain stops through the control register, unmapped place
   task t_bus;
      bus(1'h1, `REG_CONTROL, 32'h5);
      pulses(8, 0, 8, 0);
      bus(1'h1, `REG_CONTROL, 32'h2);
      pulses(8, 8, 0, 8);
      bus(1'h0, `REG_CONTROL, 32'h0);
      chk("control readback", q[4:0], 5'h02);
      bus(1'h0, 4'hC, 32'h0);
      chk("unmapped read", q, 32'h0);
      bus(1'h1, 4'hC, 32'h1F);
      pulses(8, 8, 0, 8);
      bus(1'h1, `REG_CONTROL, 32'h0);
   endtask
   // Power-down, wake by interrupt pin, then wake flag from serial start pin
   task t_sleep;
      bus(1'h1, `REG_CONTROL, 32'h8);
      pulses(4, 0, 0, 0);
      ext_interrupt_pin <= 1'h1;
      repeat (5) @(posedge clock);
      chk("irq wake", async_wake, 1);
      pulses(5, 0, 0, 0);
      osc.src(1);
      pulses(8, 8, 8, 8);
      ext_interrupt_pin <= 1'h0;
      bus(1'h0, `REG_CONTROL, 32'h0);
      chk("power down cleared", q[3], 0);
      usi_start_pin <= 1'h1;
      repeat (5) @(posedge clock);
      chk("start wake", async_wake, 1);
      usi_start_pin <= 1'h0;
      repeat (5) @(posedge clock);
      chk("wake gone", async_wake, 0);
   endtask
   // Every select code
   task t_decode;
      for (int i = 0; i < 16; i++) begin
         clock_source_select <= i[3:0];
         repeat (3) @(posedge clock);
         chk("source decode", selected_source, i[3] ? 4 : i[2:1]);
      end
      clock_source_select <= 4'h2;
      startup_time_select <= 2'h2;
      divide_by_eight_fuse <= 1'h0;
      repeat (3) @(posedge clock);
      bus(1'h0, `REG_STATUS, 32'h0);
      chk("factory default", q[7], 1);
      startup_time_select <= 2'h0;
      divide_by_eight_fuse <= 1'h1;
      repeat (3) @(posedge clock);
      bus(1'h0, `REG_STATUS, 32'h0);
      chk("not factory", q[7], 0);
   endtask
   // Programmed divide fuse, then prescaler off
   task t_div;
      restart(2'h0, 1'h0);
      osc.src(14);
      pulses(64, 8, 8, 8);
      bus(1'h1, `REG_CONTROL, 32'h10);
      pulses(16, 16, 16, 16);
   endtask
   // 4096 watchdog cycles before the fourteen source clocks
   task t_wdog;
      restart(2'h1, 1'h1);
      osc.wdog(4095);
      osc.src(20);
      chk("held at 4095", core_reset, 1);
      osc.wdog(1);
      osc.src(13);
      chk("held at 13", core_reset, 1);
      osc.src(1);
      chk("released", core_reset, 0);
   endtask

   // Main sequence
   initial begin
      t_boot;
      t_bus;
      t_sleep;
      t_decode;
      t_div;
      t_wdog;
      give_verdict;
   end
   // Hang guard
   initial begin
      repeat (40000) @(posedge clock);
      mismatches++;
      give_verdict;
   end
endmodule
